// ==== logic/dmf_framer.sv ====
// Purpose: Diagnostic multi-packet framer and manufacturer message gate.
// Assumes: Inputs synchronous to clock; frame sink holds tx_ready semantics.
// Notes: Every transmitted frame carries eight data bytes.
`timescale 1ns/1ps
`default_nettype none
module dmf_framer #(
    parameter int GAP_CYCLES = dmf_pkg::GAP_CYC,
    parameter int UNLOCK_CYCLES = dmf_pkg::UNLOCK_CYC,
    parameter logic [16:0] DIAG_DGN = 17'h1FF00,
    parameter logic [2:0] DIAG_PRIO = 3'h6,
    parameter logic [63:0] PASSWORD = 64'h0123456789ABCDEF
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic fault_valid,
    output logic fault_ready,
    input wire logic [18:0] fault_point,
    input wire logic [4:0] fault_mode,
    input wire logic [6:0] fault_count,
    input wire logic fault_count_ok,
    input wire logic [7:0] fault_ext,
    input wire logic fault_ext_ok,
    input wire logic rpt_start,
    input wire logic [7:0] rpt_status,
    input wire logic [7:0] rpt_sfc,
    input wire logic [8:0] rpt_faults,
    output logic rpt_done,
    output logic rpt_reject,
    input wire logic prop_req,
    input wire logic [7:0] prop_dest,
    input wire logic [2:0] prop_prio,
    input wire logic [63:0] prop_data,
    output logic prop_reject,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic [2:0] tx_prio,
    output logic [16:0] tx_dgn,
    output logic [63:0] tx_data,
    input wire logic [7:0] own_addr,
    input wire logic rx_valid,
    input wire logic [16:0] rx_dgn,
    input wire logic [63:0] rx_data,
    output logic rx_prop_valid,
    output logic [63:0] rx_prop_data,
    output logic unlocked
);
    typedef struct packed {
        dmf_pkg::dmf_state_t st;
        logic [10:0] pi;
        logic [10:0] len;
        logic [2:0] fb;
        logic [2:0] bi;
        logic [55:0] pbuf;
        logic [7:0] pn;
        logic [7:0] pcnt;
        logic single;
        logic prop;
        logic [7:0] status;
        logic [7:0] sfc;
        logic tx_valid;
        logic [2:0] tx_prio;
        logic [16:0] tx_dgn;
        logic [63:0] tx_data;
        logic rpt_done;
        logic rpt_reject;
        logic prop_reject;
        logic unlocked;
        logic rx_prop_valid;
        logic [63:0] rx_prop_data;
    } dmf_framer_t;
    dmf_framer_t s, d;
    dmf_stream_if #(.W(dmf_pkg::FAULT_W)) hd ();
    logic gap_ld, gap_done, unl_ld, unl_done, pop;
    logic [7:0] pbyte;
    logic [10:0] len_w;
    logic need;
    logic accept;

    dmf_fifo #(.W(dmf_pkg::FAULT_W), .D(dmf_pkg::FIFO_DEPTH)) u_fifo (
        .clock(clock),
        .rst(rst),
        .in_valid(fault_valid),
        .in_ready(fault_ready),
        .in_data({fault_point, fault_mode, fault_count, fault_count_ok, fault_ext,
            fault_ext_ok}),
        .out(hd.src)
    );
    dmf_timer #(.W(dmf_pkg::GAP_W)) u_gap (
        .clock(clock),
        .rst(rst),
        .load(gap_ld),
        .value(dmf_pkg::GAP_W'(GAP_CYCLES)),
        .done(gap_done)
    );
    dmf_timer #(.W(dmf_pkg::UNLOCK_W)) u_unlock (
        .clock(clock),
        .rst(rst),
        .load(unl_ld),
        .value(dmf_pkg::UNLOCK_W'(UNLOCK_CYCLES)),
        .done(unl_done)
    );
    assign hd.ready = pop;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        d = s;
        pop = 1'b0;
        gap_ld = 1'b0;
        unl_ld = 1'b0;
        pbyte = dmf_pkg::PAD;
        len_w = dmf_pkg::LEN_BASE + 11'(rpt_faults) * dmf_pkg::FAULT_BYTES;
        need = (s.pi < s.len) && (s.pi >= dmf_pkg::LEN_BASE);
        accept = s.tx_valid && tx_ready;
        d.rpt_done = 1'b0;
        d.rpt_reject = 1'b0;
        d.prop_reject = 1'b0;
        d.rx_prop_valid = 1'b0;
        if (s.pi == 11'h000) begin
            pbyte = s.status;
        end else if (s.pi == 11'h001) begin
            pbyte = s.sfc;
        end else if (need) begin
            unique case (s.fb)
                3'h0: pbyte = hd.data[40:33];
                3'h1: pbyte = hd.data[32:25];
                3'h2: pbyte = {hd.data[24:22], hd.data[21:17]};
                3'h3: pbyte = {1'b1, hd.data[9] ? hd.data[16:10] : dmf_pkg::COUNT_NA};
                default: pbyte = hd.data[0] ? hd.data[8:1] : dmf_pkg::EXT_NONE;
            endcase
        end
        unique case (s.st)
            dmf_pkg::ST_IDLE: begin
                if (rpt_start) begin
                    d.status = rpt_status;
                    d.sfc = rpt_sfc;
                    d.len = len_w;
                    d.pcnt = 8'((len_w + dmf_pkg::PKT_BYTES - 11'h001) / dmf_pkg::PKT_BYTES);
                    d.pi = '0;
                    d.fb = '0;
                    d.bi = '0;
                    d.pn = 8'h01;
                    d.prop = 1'b0;
                    if (rpt_faults == 9'h000 || rpt_faults > dmf_pkg::MAX_FAULTS) begin
                        d.rpt_reject = 1'b1;
                    end else if (rpt_faults == 9'h001) begin
                        d.single = 1'b1;
                        d.st = dmf_pkg::ST_COLLECT;
                    end else begin
                        d.single = 1'b0;
                        d.st = dmf_pkg::ST_INIT;
                        d.tx_valid = 1'b1;
                        d.tx_prio = DIAG_PRIO;
                        d.tx_dgn = dmf_pkg::DGN_INIT;
                        d.tx_data = {7'h00, DIAG_DGN, dmf_pkg::PAD, d.pcnt, 5'h00, len_w,
                            dmf_pkg::INIT_CTRL};
                    end
                end else if (prop_req) begin
                    if (prop_dest == dmf_pkg::ADDR_GLOBAL) begin
                        d.prop_reject = 1'b1;
                    end else begin
                        d.single = 1'b1;
                        d.prop = 1'b1;
                        d.st = dmf_pkg::ST_SEND;
                        d.tx_valid = 1'b1;
                        d.tx_prio = (prop_prio < dmf_pkg::PRIO_DEF) ? prop_prio
                            : dmf_pkg::PRIO_DEF;
                        d.tx_dgn = {dmf_pkg::DGN_PROP[16:8], prop_dest};
                        d.tx_data = prop_data;
                    end
                end
            end
            dmf_pkg::ST_INIT: begin
                if (accept) begin
                    d.tx_valid = 1'b0;
                    d.st = dmf_pkg::ST_COLLECT;
                end
            end
            dmf_pkg::ST_COLLECT: begin
                if (!(need && !hd.valid)) begin
                    d.pbuf[s.bi * 8 +: 8] = pbyte;
                    if (s.pi < s.len) begin
                        d.pi = s.pi + 11'h001;
                    end
                    if (need) begin
                        d.fb = (s.fb == dmf_pkg::LAST_FIELD) ? 3'h0 : s.fb + 3'h1;
                        pop = (s.fb == dmf_pkg::LAST_FIELD);
                    end
                    d.bi = s.bi + 3'h1;
                    if (s.bi == dmf_pkg::LAST_SLOT) begin
                        d.bi = '0;
                        d.st = dmf_pkg::ST_SEND;
                        d.tx_valid = 1'b1;
                        if (s.single) begin
                            d.tx_prio = DIAG_PRIO;
                            d.tx_dgn = DIAG_DGN;
                            d.tx_data = {dmf_pkg::PAD, d.pbuf};
                        end else begin
                            d.tx_prio = dmf_pkg::PRIO_DEF;
                            d.tx_dgn = dmf_pkg::DGN_DATA;
                            d.tx_data = {d.pbuf, s.pn};
                        end
                    end
                end
            end
            dmf_pkg::ST_SEND: begin
                if (accept) begin
                    d.tx_valid = 1'b0;
                    if (s.single || s.pn == s.pcnt) begin
                        d.st = dmf_pkg::ST_IDLE;
                        d.rpt_done = !s.prop;
                    end else begin
                        d.pn = s.pn + 8'h01;
                        gap_ld = 1'b1;
                        d.st = dmf_pkg::ST_GAP;
                    end
                end
            end
            dmf_pkg::ST_GAP: begin
                if (gap_done) begin
                    d.st = dmf_pkg::ST_COLLECT;
                end
            end
            default: begin
                d.st = dmf_pkg::ST_IDLE;
            end
        endcase
        if (rpt_start && s.st != dmf_pkg::ST_IDLE) begin
            d.rpt_reject = 1'b1;
        end
        if (s.unlocked && unl_done) begin
            d.unlocked = 1'b0;
        end
        if (rx_valid && rx_dgn[16:8] == dmf_pkg::DGN_PROP[16:8] && rx_dgn[7:0] == own_addr) begin
            if (rx_data == PASSWORD) begin
                d.unlocked = 1'b1;
                unl_ld = 1'b1;
            end else if (s.unlocked && !unl_done) begin
                d.rx_prop_valid = 1'b1;
                d.rx_prop_data = rx_data;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s <= '{st: dmf_pkg::ST_IDLE, default: '0};
        end else begin
            s <= d;
        end
    end

    assign rpt_done = s.rpt_done;
    assign rpt_reject = s.rpt_reject;
    assign prop_reject = s.prop_reject;
    assign tx_valid = s.tx_valid;
    assign tx_prio = s.tx_prio;
    assign tx_dgn = s.tx_dgn;
    assign tx_data = s.tx_data;
    assign rx_prop_valid = s.rx_prop_valid;
    assign rx_prop_data = s.rx_prop_data;
    assign unlocked = s.unlocked;

    ////////////////////////////////////////////////////////////////////////////
    // Helper counters follow data packet spacing and numbering.
    logic [31:0] since_q;
    logic seen_q;
    logic [7:0] last_pn_q;
    logic data_acc, init_acc;
    assign data_acc = accept && s.tx_dgn == dmf_pkg::DGN_DATA;
    assign init_acc = accept && s.tx_dgn == dmf_pkg::DGN_INIT;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            since_q <= '0;
            seen_q <= 1'b0;
            last_pn_q <= '0;
        end else begin
            since_q <= data_acc ? 32'h0000_0001 : since_q + 32'h0000_0001;
            if (init_acc) begin
                seen_q <= 1'b0;
                last_pn_q <= '0;
            end else if (data_acc) begin
                seen_q <= 1'b1;
                last_pn_q <= s.tx_data[7:0];
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_data_acc;
        data_acc;
    endsequence
    sequence s_busy_start;
        rpt_start && s.st != dmf_pkg::ST_IDLE;
    endsequence

    property p_gap;
        s_data_acc and seen_q |-> since_q >= 32'(GAP_CYCLES);
    endproperty
    a_gap: assert property (p_gap) else $error("Data packets too close.");
    property p_pn_seq;
        s_data_acc |-> s.tx_data[7:0] == last_pn_q + 8'h01;
    endproperty
    a_pn_seq: assert property (p_pn_seq) else $error("Packet number out of order.");
    property p_data_pkt;
        s.tx_valid && s.tx_dgn == dmf_pkg::DGN_DATA |->
            s.tx_prio == 3'h6 && s.tx_data[7:0] != 8'h00 && s.tx_data[7:0] <= s.pcnt;
    endproperty
    a_data_pkt: assert property (p_data_pkt) else $error("Bad data packet.");
    property p_init_ctrl;
        s.tx_valid && s.tx_dgn == dmf_pkg::DGN_INIT |->
            s.tx_data[7:0] == 8'h20 && s.tx_data[58:40] == {2'b00, DIAG_DGN};
    endproperty
    a_init_ctrl: assert property (p_init_ctrl) else $error("Bad initial packet.");
    property p_prop_dest;
        s.tx_valid && s.tx_dgn[16:8] == dmf_pkg::DGN_PROP[16:8] |-> s.tx_dgn[7:0] != 8'hFF;
    endproperty
    a_prop_dest: assert property (p_prop_dest) else $error("Global destination used.");
    property p_single_rsvd;
        s.tx_valid && s.tx_dgn == DIAG_DGN |-> s.tx_data[47] && s.tx_data[63:56] == 8'hFF;
    endproperty
    a_single_rsvd: assert property (p_single_rsvd) else $error("Count byte bit 7 low.");
    property p_gate;
        rx_prop_valid |-> $past(s.unlocked);
    endproperty
    a_gate: assert property (p_gate) else $error("Message passed while locked.");
    property p_expire;
        s.unlocked && unl_done && !unl_ld |=> !s.unlocked;
    endproperty
    a_expire: assert property (p_expire) else $error("Password did not expire.");
    property p_busy;
        s_busy_start |=> rpt_reject ##1 !rpt_done || s.st != dmf_pkg::ST_IDLE;
    endproperty
    a_busy: assert property (p_busy) else $error("Overlapping report not refused.");
endmodule
`default_nettype wire

// ==== logic/dmf_pkg.sv ====
// Purpose: Shared constants and types of the diagnostic multi-packet framer.
// Assumes: 50 MHz node clock.
// Notes: Group numbers are 17 bits wide.
package dmf_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int GAP_MS = 50;
    localparam int GAP_CYC = GAP_MS * (CLK_HZ / 1000);
    localparam int UNLOCK_MS = 10000;
    localparam int UNLOCK_CYC = UNLOCK_MS * (CLK_HZ / 1000);
    localparam logic [16:0] DGN_INIT = 17'h0ECFF;
    localparam logic [16:0] DGN_DATA = 17'h0EBFF;
    localparam logic [16:0] DGN_PROP = 17'h0EF00;
    localparam logic [7:0] INIT_CTRL = 8'h20;
    localparam logic [2:0] PRIO_DEF = 3'h6;
    localparam logic [7:0] ADDR_GLOBAL = 8'hFF;
    localparam logic [7:0] PAD = 8'hFF;
    localparam logic [6:0] COUNT_NA = 7'h7F;
    localparam logic [7:0] EXT_NONE = 8'hFF;
    localparam logic [8:0] MAX_FAULTS = 9'h164;
    localparam logic [10:0] LEN_BASE = 11'h002;
    localparam logic [10:0] FAULT_BYTES = 11'h005;
    localparam logic [10:0] PKT_BYTES = 11'h007;
    localparam logic [2:0] LAST_FIELD = 3'h4;
    localparam logic [2:0] LAST_SLOT = 3'h6;
    localparam int FAULT_W = 41;
    localparam int FIFO_DEPTH = 8;
    localparam int GAP_W = 22;
    localparam int UNLOCK_W = 30;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_COLLECT = 3'b001,
        ST_SEND = 3'b010,
        ST_GAP = 3'b011,
        ST_INIT = 3'b100
    } dmf_state_t;
endpackage

// ==== logic/dmf_stream_if.sv ====
// Purpose: Valid/ready word stream between framer modules.
// Assumes: Single clock domain.
// Notes: Data is held while valid is high and ready is low.
`timescale 1ns/1ps
`default_nettype none
interface dmf_stream_if #(parameter int W = 8);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ==== logic/dmf_fifo.sv ====
// Purpose: Fault record FIFO with valid/ready on both sides.
// Assumes: Single clock, asynchronous active-high reset.
// Notes: Full and empty are registered flags.
`timescale 1ns/1ps
`default_nettype none
module dmf_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    dmf_stream_if.src out
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic full;
        logic empty;
        logic not_full;
    } dmf_fifo_t;
    dmf_fifo_t s, d;
    logic push, pop;

    always_comb begin
        d = s;
        push = in_valid && !s.full;
        pop = out.ready && !s.empty;
        if (push) begin
            d.mem[s.wp] = in_data;
            d.wp = (s.wp == AW'(D - 1)) ? '0 : s.wp + 1'b1;
        end
        if (pop) begin
            d.rp = (s.rp == AW'(D - 1)) ? '0 : s.rp + 1'b1;
        end
        d.cnt = s.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
        d.full = (d.cnt == (AW + 1)'(D));
        d.empty = (d.cnt == '0);
        d.not_full = !d.full;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s <= '{default: '0, empty: 1'b1, not_full: 1'b1};
        end else begin
            s <= d;
        end
    end

    assign in_ready = s.not_full;
    assign out.valid = !s.empty;
    assign out.data = s.mem[s.rp];
endmodule
`default_nettype wire

// ==== logic/dmf_timer.sv ====
// Purpose: Loadable down-counter reporting expiry.
// Assumes: Single clock, asynchronous active-high reset.
// Notes: Done is low from the edge after a load until the count runs out.
`timescale 1ns/1ps
`default_nettype none
module dmf_timer #(
    parameter int W = 8
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic load,
    input wire logic [W-1:0] value,
    output logic done
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } dmf_timer_t;
    dmf_timer_t s, d;

    always_comb begin
        d = s;
        if (load) begin
            d.cnt = value;
        end else if (s.cnt != '0) begin
            d.cnt = s.cnt - 1'b1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= d;
        end
    end

    assign done = (s.cnt == '0);
endmodule
`default_nettype wire

// ==== test/dmf_bus_node.sv ====
// Purpose: Model of the other nodes that take frames off the bus.
// Assumes: A frame is taken on an edge with tx_valid and tx_ready high.
// Notes: In slow mode the ready line stalls at random.
`timescale 1ns/1ps
`default_nettype none
module dmf_bus_node (
    input wire logic clock,
    input wire logic rst,
    input wire logic slow,
    output logic tx_ready
);
    logic [7:0] lfsr_q;
    always_ff @(negedge clock or posedge rst) begin
        if (rst) begin
            lfsr_q <= 8'h5A;
            tx_ready <= 1'b0;
        end else begin
            lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
            tx_ready <= slow ? lfsr_q[0] : 1'b1;
        end
    end
endmodule
`default_nettype wire

// ==== test/dmf_framer_tb.sv ====
// Purpose: Self-checking bench of the diagnostic framer.
// Assumes: Short gap and unlock counts.
// Notes: Faults and data come from a seeded xorshift.
`timescale 1ns/1ps
`default_nettype none
module dmf_framer_tb;
    localparam int GAP = 20;
    localparam int UNL = 50;
    localparam logic [16:0] DIAG = 17'h1FF00;
    localparam logic [63:0] PW = 64'h0123456789ABCDEF;
    logic clock, rst, fault_valid, fault_ready, fault_count_ok, fault_ext_ok, slow;
    logic [18:0] fault_point;
    logic [4:0] fault_mode;
    logic [6:0] fault_count;
    logic [7:0] fault_ext, rpt_status, rpt_sfc, prop_dest, own_addr;
    logic [8:0] rpt_faults;
    logic rpt_start, rpt_done, rpt_reject, prop_req, prop_reject, tx_valid, tx_ready;
    logic [2:0] prop_prio, tx_prio;
    logic [16:0] tx_dgn, rx_dgn;
    logic [63:0] prop_data, tx_data, rx_data, rx_prop_data, last_rx;
    logic rx_valid, rx_prop_valid, unlocked, seen;
    int err_total, n_checks, cyc, last_pkt, n_rx, i;
    logic [31:0] seed = 32'h52;
    logic [83:0] got_q[$];
    logic [7:0] pl[0:63];
    dmf_framer #(.GAP_CYCLES(GAP), .UNLOCK_CYCLES(UNL), .DIAG_DGN(DIAG), .PASSWORD(PW)) i_dut (
        .clock, .rst, .fault_valid, .fault_ready, .fault_point, .fault_mode, .fault_count,
        .fault_count_ok, .fault_ext, .fault_ext_ok, .rpt_start, .rpt_status, .rpt_sfc,
        .rpt_faults, .rpt_done, .rpt_reject, .prop_req, .prop_dest, .prop_prio, .prop_data,
        .prop_reject, .tx_valid, .tx_ready, .tx_prio, .tx_dgn, .tx_data, .own_addr, .rx_valid,
        .rx_dgn, .rx_data, .rx_prop_valid, .rx_prop_data, .unlocked);
    dmf_bus_node i_node (.clock, .rst, .slow, .tx_ready);
    ////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    task automatic results();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clock);
        err_total++;
        results();
    end
    task automatic check(input logic [83:0] got, input logic [83:0] exp, input string msg);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [63:0] pk(input int base, input int len, input int num);
        logic [63:0] b;
        int j, s;
        s = (num > 0) ? 1 : 0;
        b[7:0] = 8'(num);
        for (j = s; j < 8; j++) b[j*8 +: 8] = (base + j - s < len) ? pl[base + j - s] : 8'hFF;
        return b;
    endfunction
    always @(posedge clock) begin
        cyc++;
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            got_q.push_back({tx_prio, tx_dgn, tx_data});
            if (tx_dgn === 17'h0EBFF) begin
                if (last_pkt >= 0) check(84'(cyc - last_pkt >= GAP), 84'h1, "gap");
                last_pkt = cyc;
            end
        end
        if (rx_prop_valid === 1'b1) begin
            n_rx++;
            last_rx = rx_prop_data;
        end
    end
    ////////////////////////////////////////
    task automatic wait_hi(ref logic s, input int lim, output logic hit);
        int k;
        hit = 1'b0;
        for (k = 0; k < lim && !hit; k++) begin
            hit = (s === 1'b1);
            if (!hit) begin
                @(posedge clock);
                #1;
            end
        end
        hit = hit || (s === 1'b1);
    endtask
    task automatic feed(input int f);
        logic [31:0] r;
        r = rnd();
        @(negedge clock);
        fault_valid = 1'b1;
        fault_point = r[18:0];
        fault_mode = r[23:19];
        fault_count = r[30:24];
        fault_ext = r[31:24];
        fault_count_ok = (f != 1);
        fault_ext_ok = (f != 1);
        pl[2+5*f] = r[18:11];
        pl[3+5*f] = r[10:3];
        pl[4+5*f] = {r[2:0], r[23:19]};
        pl[5+5*f] = {1'b1, (f != 1) ? r[30:24] : 7'h7F};
        pl[6+5*f] = (f != 1) ? r[31:24] : 8'hFF;
    endtask
    task automatic run_rpt(input int n);
        logic [31:0] r;
        int len, cnt, k;
        r = rnd();
        len = 2 + 5 * n;
        cnt = (len + 6) / 7;
        pl[0] = r[7:0];
        pl[1] = r[15:8];
        slow = r[16];
        for (k = 0; k < n; k++) feed(k);
        @(negedge clock);
        fault_valid = 1'b0;
        check(fault_ready, n < 8, "fifo full flag");
        got_q.delete();
        last_pkt = -1;
        rpt_start = 1'b1;
        rpt_status = pl[0];
        rpt_sfc = pl[1];
        rpt_faults = 9'(n);
        @(negedge clock);
        rpt_start = 1'b0;
        if (n > 1) begin
            @(negedge clock);
            rpt_start = 1'b1;
            @(negedge clock);
            rpt_start = 1'b0;
            wait_hi(rpt_reject, 4, seen);
            check(seen, 1, "busy start");
        end
        wait_hi(rpt_done, 3000, seen);
        check(seen, 1, "report done");
        if (n == 1) begin
            check(got_q.size(), 1, "frames");
            check(got_q[0], {3'h6, DIAG, pk(0, len, 0)}, "single");
        end else begin
            check(got_q.size(), cnt + 1, "frames");
            check(got_q[0], {3'h6, 17'h0ECFF, 7'h0, DIAG, 8'hFF, 8'(cnt), 8'(len >> 8), 8'(len),
                8'h20}, "initial");
            for (k = 1; k <= cnt; k++)
                check(got_q[k], {3'h6, 17'h0EBFF, pk((k - 1) * 7, len, k)}, "data");
        end
    endtask
    task automatic prop(input logic [7:0] d, input logic [2:0] p);
        logic [63:0] v;
        int w;
        v = {rnd(), rnd()};
        got_q.delete();
        @(negedge clock);
        prop_req = 1'b1;
        prop_dest = d;
        prop_prio = p;
        prop_data = v;
        @(negedge clock);
        prop_req = 1'b0;
        if (d == 8'hFF) begin
            wait_hi(prop_reject, 4, seen);
            check(seen, 1, "global dest");
        end else begin
            for (w = 0; w < 60 && got_q.size() == 0; w++) @(negedge clock);
            check(got_q[0], {(p > 3'h6) ? 3'h6 : p, 1'b0, 8'hEF, d, v}, "maker msg");
        end
    endtask
    task automatic rx(input logic [7:0] d, input logic [63:0] v);
        @(negedge clock);
        rx_valid = 1'b1;
        rx_dgn = {1'b0, 8'hEF, d};
        rx_data = v;
        @(negedge clock);
        rx_valid = 1'b0;
        repeat (3) @(negedge clock);
    endtask
    ////////////////////////////////////////
    initial begin
        {rst, fault_valid, fault_point, fault_mode, fault_count, fault_count_ok} = 1'b1 << 33;
        {fault_ext, fault_ext_ok, rpt_start, rpt_status, rpt_sfc, rpt_faults, slow} = '0;
        {prop_req, prop_dest, prop_prio, prop_data, rx_valid, rx_dgn, rx_data} = '0;
        own_addr = 8'h3C;
        repeat (4) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        rx(8'h3C, 64'h1);
        check(n_rx, 0, "locked drop");
        rx(8'h3C, PW);
        check(unlocked, 1, "unlock");
        rx(8'h3C, {rnd(), rnd()});
        check({n_rx[7:0], last_rx}, {8'h1, rx_data}, "passed msg");
        rx(8'h3D, 64'h2);
        repeat (25) @(negedge clock);
        check({n_rx[7:0], unlocked}, 9'h3, "still open");
        repeat (25) @(negedge clock);
        check(unlocked, 0, "expired");
        for (int k = 0; k < 6; k++) run_rpt((k == 1) ? 8 : 1 + rnd() % 8);
        run_rpt(2);
        for (i = 0; i < 2; i++) begin
            @(negedge clock);
            rpt_start = 1'b1;
            rpt_faults = i ? 9'h165 : 9'h0;
            @(negedge clock);
            rpt_start = 1'b0;
            wait_hi(rpt_reject, 4, seen);
            check(seen, 1, "bad count");
        end
        prop(8'hFF, 3'h6);
        for (i = 0; i < 4; i++) prop(8'(rnd() % 255), 3'(rnd()));
        results();
    end
endmodule
`default_nettype wire
